// ==== tb/nfcfm_meas_model.sv ====
// Purpose: presence measurement engine answering the wake timer
// Assumes: one answer four cycles after each start pulse
// Notes:   value bus inverts itself every cycle outside its valid cycle
`timescale 1ns/1ps
module nfcfm_meas_model (
   input  wire logic       pclk,
   input  wire logic       meas_start,
   input  wire logic [7:0] result,
   output logic            meas_done = 1'b0,
   output logic [7:0]      meas_value = 8'h00
);
   logic [2:0] pipe_ff = 3'h0;
   // delay line to the answer; a stale bus must never look valid
   always @(posedge pclk) begin
      pipe_ff <= {pipe_ff[1:0], meas_start};
      meas_done <= pipe_ff[2];
      meas_value <= pipe_ff[2] ? result : ~meas_value;
   end
endmodule : nfcfm_meas_model

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench of the nfc front-end mode control
// Assumes: apb master in the tasks below, one word per access
// Notes:   settle waits cover the two-edge input synchronisers
`timescale 1ns/1ps
module tb_top;
   logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, tx_mod_in = 1'b0, load_mod_in = 1'b0;
   logic        ext_clk_present = 1'b0, rc_clk = 1'b0, rerr;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000, rdata;
   logic [7:0]  result = 8'h55;
   wire logic [31:0] prdata;
   wire logic [7:0]  meas_value, driver_segments;
   wire logic [3:0]  amplitude_mod_level;
   wire logic        pready, pslverr, irq, meas_done, meas_start, osc_on;
   wire logic        regulator_on, fifo_access_ok, antenna_driver_a;
   wire logic        antenna_driver_b, am_supply_sel, external_gate_out;
   wire logic        slow_ramp, rx_power, rx_auto_channel, rx_channel_q;
   wire logic        demod_mixer_sel;
   int               failures = 0, checks_done = 0;
   int               starts = 0;
   localparam int    RAMP_HOLD_CYC = 50000; // 2 ms of 40 ns cycles
   // rc clock is slow and unrelated to pclk
   always #20 pclk = ~pclk;
   always #110 rc_clk = ~rc_clk;
   // measurement requests seen, proves the wake timer is running
   always @(posedge pclk) if (meas_start === 1'b1) starts++;
   nfcfm_top DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
      .pwdata, .prdata, .pready, .pslverr, .irq, .tx_mod_in, .load_mod_in,
      .ext_clk_present, .rc_clk, .meas_done, .meas_value, .meas_start,
      .regulator_on, .osc_on, .fifo_access_ok, .antenna_driver_a,
      .antenna_driver_b, .driver_segments, .am_supply_sel,
      .amplitude_mod_level, .external_gate_out, .slow_ramp, .rx_power,
      .rx_auto_channel, .rx_channel_q, .demod_mixer_sel);
   nfcfm_meas_model meas (.pclk, .meas_start, .result, .meas_done,
      .meas_value);
   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   // pready and the answer are taken at the completing rising edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int k;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 20);
      chk(pready, 1'b1);
      rdata = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd(input logic [11:0] a, input logic [31:0] exp,
                     input logic err);
      apb(1'b0, a, 32'h0000_0000);
      chk(rdata, exp);
      chk(rerr, err);
   endtask : rd
   // the settle wait lets registered outputs land before any check
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
      repeat (4) @(negedge pclk);
   endtask : wr
   task automatic wait_irq(input int lim);
      int k;
      k = 0;
      while (irq !== 1'b1 && k < lim) begin
         @(negedge pclk);
         k++;
      end
      chk(irq, 1'b1);
   endtask : wait_irq
   task automatic stop_test;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : stop_test
   ////////////////////////////////////////////////////////////////////////
   // a hang counts as a failure; covers osc settle and the ramp hold
   initial begin
      repeat (80000) @(posedge pclk);
      failures++;
      stop_test();
   end
   initial begin
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      rd(nfcfm_pkg::OFF_OP_CTRL, 32'h0000_0000, 1'b0);
      chk({regulator_on, osc_on, fifo_access_ok}, 3'b000);
      wr(nfcfm_pkg::OFF_TX_DRV, 32'h0000_00A3);
      rd(nfcfm_pkg::OFF_TX_DRV, 32'h0000_00A3, 1'b0);
      chk(amplitude_mod_level, 4'hA);
      wr(nfcfm_pkg::OFF_RAM_BASE, 32'h0000_0011);
      chk(rerr, 1'b1);
      rd(12'h020, 32'h0000_0000, 1'b1);
      // wake mode: equal result stays quiet, a change interrupts
      wr(nfcfm_pkg::OFF_WAKE_CFG, 32'h0000_5501);
      wr(nfcfm_pkg::OFF_OP_CTRL, 32'h0000_0004);
      rd(nfcfm_pkg::OFF_STATUS, 32'h0000_0010, 1'b0);
      repeat (100) @(negedge pclk);
      chk(irq, 1'b0);
      chk(starts != 0, 1'b1);
      result <= 8'h5A;
      wait_irq(300);
      result <= 8'h55;
      repeat (60) @(negedge pclk);
      wr(nfcfm_pkg::OFF_STATUS, 32'h0000_0002);
      chk(irq, 1'b0);
      wr(nfcfm_pkg::OFF_OP_CTRL, 32'h0000_000C);
      rd(nfcfm_pkg::OFF_STATUS, 32'h0000_0000, 1'b0);
      wr(nfcfm_pkg::OFF_OP_CTRL, 32'h0000_0080);
      chk({regulator_on, osc_on, fifo_access_ok}, 3'b111);
      wr(nfcfm_pkg::OFF_RAM_BASE + 12'h004, 32'h0000_0033);
      rd(nfcfm_pkg::OFF_RAM_BASE + 12'h004, 32'h0000_0033, 1'b0);
      chk(irq, 1'b0);
      wait_irq(3000);
      rd(nfcfm_pkg::OFF_STATUS, 32'h0000_000D, 1'b0);
      wr(nfcfm_pkg::OFF_STATUS, 32'h0000_0001);
      chk(irq, 1'b0);
      wr(nfcfm_pkg::OFF_OP_CTRL, 32'h0000_0088);
      chk({antenna_driver_a, antenna_driver_b, rx_power}, 3'b110);
      for (int f = 0; f < 10; f++) begin
         wr(nfcfm_pkg::OFF_TX_DRV, 32'(f));
         chk(driver_segments, 8'hFF >> f);
      end
      @(posedge pclk) tx_mod_in <= 1'b1;
      for (int m = 0; m < 2; m++) begin
         wr(nfcfm_pkg::OFF_MODE_DEF, 32'(m));
         chk({antenna_driver_a, antenna_driver_b, am_supply_sel},
             m ? 3'b111 : 3'b000);
      end
      @(posedge pclk) tx_mod_in <= 1'b0;
      for (int s = 0; s < 2; s++) begin
         wr(nfcfm_pkg::OFF_IO_CFG, 32'(1 + 2 * s));
         chk({antenna_driver_a, antenna_driver_b}, s ? 2'b01 : 2'b10);
      end
      // channel table, both demodulators, receiver on with field off
      for (int i = 0; i < 8; i++) begin
         wr(nfcfm_pkg::OFF_OP_CTRL, 32'h0000_00C0 | 32'(i[2:1]) << 4);
         wr(nfcfm_pkg::OFF_RX_CFG, 32'(i[1:0]));
         chk(rx_auto_channel, i[2:1] == 0);
         chk(rx_channel_q, i[0] && i[2:1] != 0);
         chk({demod_mixer_sel, rx_power, antenna_driver_a,
              antenna_driver_b}, {i[1], 3'b100});
      end
      // slow ramp: set with the field off, hold 2 ms, field on, clear
      wr(nfcfm_pkg::OFF_IO_CFG, 32'h0000_0004);
      repeat (RAMP_HOLD_CYC) @(negedge pclk);
      chk({slow_ramp, antenna_driver_a}, 2'b10);
      wr(nfcfm_pkg::OFF_OP_CTRL, 32'h0000_0088);
      chk({slow_ramp, antenna_driver_a}, 2'b11);
      wr(nfcfm_pkg::OFF_IO_CFG, 32'h0000_0000);
      chk(slow_ramp, 1'b0);
      // impedances go in before target mode is entered
      wr(nfcfm_pkg::OFF_OP_CTRL, 32'h0000_0088);
      wr(nfcfm_pkg::OFF_LM_CFG, 32'h0000_0342);
      wr(nfcfm_pkg::OFF_MODE_DEF, 32'h0000_0002);
      @(posedge pclk) ext_clk_present <= 1'b1;
      for (int j = 0; j < 4; j++) begin
         wr(nfcfm_pkg::OFF_LM_CFG, 32'h0000_0342 | 32'(j[1]) << 10);
         @(posedge pclk) load_mod_in <= j[0];
         // segments need a fourth edge: sync, sync, impedance, driver
         repeat (5) @(negedge pclk);
         chk(external_gate_out, j[0] ^ j[1]);
         chk(driver_segments, j[0] ? 8'hFF >> 4 : 8'hFF >> 2);
      end
      stop_test();
   end
endmodule : tb_top

// ==== verilog/nfcfm_ctl_if.sv ====
// Purpose: carrier between the mode controller and its helpers
// Assumes: single pclk domain
// Notes:   wake measurement data passes straight through from the top
`timescale 1ns/1ps
interface nfcfm_ctl_if;
   logic       osc_on;
   logic       osc_ok;
   logic       wake_run;
   logic [7:0] wake_period;
   logic [7:0] wake_ref;
   logic       meas_start;
   logic       meas_done;
   logic [7:0] meas_value;
   logic       wake_evt;
   modport ctl  (output osc_on, wake_run, wake_period, wake_ref,
                 meas_done, meas_value, input osc_ok, meas_start, wake_evt);
   modport osc  (input osc_on, output osc_ok);
   modport wake (input wake_run, wake_period, wake_ref, meas_done,
                 meas_value, output meas_start, wake_evt);
endinterface : nfcfm_ctl_if

// ==== verilog/nfcfm_osc_mon.sv ====
// Purpose: declares the crystal stable after a settle count
// Assumes: settle count long enough for the crystal in use
// Notes:   drops at the next edge after the oscillator is switched off
`timescale 1ns/1ps
module nfcfm_osc_mon #(
   parameter int SETTLE_CYC = nfcfm_pkg::OSC_SETTLE_CYC
) (
   input wire logic  pclk,
   input wire logic  presetn,
   nfcfm_ctl_if.osc  ctl
);
   typedef struct packed {
      logic [15:0] cnt;
      logic        ok;
   } nfcfm_osc_t;
   nfcfm_osc_t st_ff, nxt_st;
   ////////////////////////////////////////////////////////////////////////
   // count while the oscillator runs, hold ok at the end
   always_comb begin
      nxt_st = st_ff;
      if (!ctl.osc_on) begin
         nxt_st.cnt = 16'h0000;
         nxt_st.ok  = 1'b0;
      end else if (st_ff.cnt == 16'(SETTLE_CYC - 1)) begin
         nxt_st.ok = 1'b1;
      end else begin
         nxt_st.cnt = st_ff.cnt + 16'h0001;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) st_ff <= '0;
      else          st_ff <= nxt_st;
   end
   assign ctl.osc_ok = st_ff.ok;
endmodule : nfcfm_osc_mon

// ==== verilog/nfcfm_pkg.sv ====
// Purpose: shared constants and types of the nfc front-end mode control
// Assumes: 32-bit apb, one register per aligned word
// Notes:   bit positions other than the oscillator enable are local picks
package nfcfm_pkg;
   // register byte offsets
   localparam logic [11:0] OFF_OP_CTRL  = 12'h000;
   localparam logic [11:0] OFF_IO_CFG   = 12'h004;
   localparam logic [11:0] OFF_MODE_DEF = 12'h008;
   localparam logic [11:0] OFF_TX_DRV   = 12'h00C;
   localparam logic [11:0] OFF_LM_CFG   = 12'h010;
   localparam logic [11:0] OFF_RX_CFG   = 12'h014;
   localparam logic [11:0] OFF_WAKE_CFG = 12'h018;
   localparam logic [11:0] OFF_STATUS   = 12'h01C;
   localparam logic [11:0] OFF_RAM_BASE = 12'h100;
   localparam int          RAM_DEPTH    = 48;
   // operation control bits
   localparam int B_OSC_EN   = 7;
   localparam int B_RX_EN    = 6;
   localparam int B_RX_SINGLE = 5;
   localparam int B_RX_MAN   = 4;
   localparam int B_TX_EN    = 3;
   localparam int B_WAKEUP   = 2;
   // io configuration bits
   localparam int B_SINGLE   = 0;
   localparam int B_OUT_SEL  = 1;
   localparam int B_SLOW_UP  = 2;
   // mode definition bits
   localparam int B_AM_SEL   = 0;
   localparam int B_PT_MODE  = 1;
   // load modulation configuration bits
   localparam int B_LM_DRI   = 8;
   localparam int B_LM_EXT   = 9;
   localparam int B_LM_INV   = 10;
   // receiver configuration bits
   localparam int B_CH_PICK  = 0;
   localparam int B_DEMOD_MIX = 1;
   // status bits, write one to clear the two sticky flags
   localparam int B_ST_OSC   = 0;
   localparam int B_ST_WAKE  = 1;
   localparam logic [7:0]  RST_REG8  = 8'h00;
   localparam logic [15:0] RST_REG16 = 16'h0000;
   // oscillator settle time
   localparam int OSC_SETTLE_US = 100;
   localparam int CLK_MHZ       = 25;
   localparam int OSC_SETTLE_CYC = OSC_SETTLE_US * CLK_MHZ;
   typedef enum logic [1:0] {
      NFCFM_PWRDN,
      NFCFM_READY,
      NFCFM_WAKEUP
   } nfcfm_mode_t;
endpackage : nfcfm_pkg

// ==== verilog/nfcfm_top.sv ====
// Purpose: operating mode, driver and receiver control of the nfc front end
// Assumes: modulation and clock-detect inputs arrive asynchronously
// Notes:   one wait state on every apb access
`timescale 1ns/1ps
module nfcfm_top (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output wire logic [31:0] prdata,
   output wire logic        pready,
   output wire logic        pslverr,
   output wire logic        irq,
   input  wire logic        tx_mod_in,
   input  wire logic        load_mod_in,
   input  wire logic        ext_clk_present,
   input  wire logic        rc_clk,
   input  wire logic        meas_done,
   input  wire logic [7:0]  meas_value,
   output wire logic        meas_start,
   output wire logic        regulator_on,
   output wire logic        osc_on,
   output wire logic        fifo_access_ok,
   output wire logic        antenna_driver_a,
   output wire logic        antenna_driver_b,
   output wire logic [7:0]  driver_segments,
   output wire logic        am_supply_sel,
   output wire logic [3:0]  amplitude_mod_level,
   output wire logic        external_gate_out,
   output wire logic        slow_ramp,
   output wire logic        rx_power,
   output wire logic        rx_auto_channel,
   output wire logic        rx_channel_q,
   output wire logic        demod_mixer_sel
);
   typedef struct packed {
      logic [7:0]          op;
      logic [7:0]          io;
      logic [7:0]          mdef;
      logic [7:0]          txd;
      logic [15:0]         lm;
      logic [7:0]          rxc;
      logic [15:0]         wake;
      logic                osc_flag;
      logic                wake_flag;
      logic                osc_ok_d;
      logic                rdy;
      logic                slverr;
      logic [31:0]         rdata;
      nfcfm_pkg::nfcfm_mode_t mode;
      logic                tm_s1;
      logic                tm_s2;
      logic                lm_s1;
      logic                lm_s2;
      logic                xc_s1;
      logic                xc_s2;
      logic [3:0]          imp;
      logic [7:0]          segs;
      logic                drv_a;
      logic                drv_b;
      logic                am_sup;
      logic                ext_gate;
   } nfcfm_st_t;
   nfcfm_st_t   st_ff, nxt_st;
   nfcfm_ctl_if ctl ();
   logic [7:0]  ram [0:nfcfm_pkg::RAM_DEPTH-1];
   logic        acc, commit, ram_hit, ram_wr;
   logic [5:0]  ram_idx;
   logic        tx_on, ook;
   ////////////////////////////////////////////////////////////////////////
   // segment mask: each step up to 8 switches one more msb segment off, 8 and above give all off
   function automatic logic [7:0] seg_mask(input logic [3:0] r);
      if (r > 4'h8) return 8'h00;
      return 8'hFF >> r;
   endfunction : seg_mask
   ////////////////////////////////////////////////////////////////////////
   // helpers
   nfcfm_osc_mon  u_osc  (.pclk(pclk), .presetn(presetn), .ctl(ctl));
   nfcfm_wake_tmr u_wake (.pclk(pclk), .presetn(presetn), .rc_clk(rc_clk),
                          .ctl(ctl));
   assign ctl.osc_on      = st_ff.op[nfcfm_pkg::B_OSC_EN];
   assign ctl.wake_run    = (st_ff.mode == nfcfm_pkg::NFCFM_WAKEUP);
   assign ctl.wake_period = st_ff.wake[7:0];
   assign ctl.wake_ref    = st_ff.wake[15:8];
   assign ctl.meas_done   = meas_done;
   assign ctl.meas_value  = meas_value;
   ////////////////////////////////////////////////////////////////////////
   // apb decode: first access cycle prepares the answer, second commits
   assign acc     = psel & penable & ~st_ff.rdy;
   assign commit  = psel & penable & st_ff.rdy;
   assign ram_hit = (paddr >= nfcfm_pkg::OFF_RAM_BASE) &&
                    (paddr < nfcfm_pkg::OFF_RAM_BASE +
                     12'(4 * nfcfm_pkg::RAM_DEPTH));
   assign ram_idx = 6'((paddr - nfcfm_pkg::OFF_RAM_BASE) >> 2);
   // target ram only reachable in ready mode
   assign ram_wr  = commit & pwrite & ram_hit & ~st_ff.slverr;
   assign tx_on   = st_ff.op[nfcfm_pkg::B_TX_EN] &
                    st_ff.op[nfcfm_pkg::B_OSC_EN];
   assign ook     = ~st_ff.mdef[nfcfm_pkg::B_AM_SEL];
   ////////////////////////////////////////////////////////////////////////
   // next state of every register
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.rdy   = acc;
      nxt_st.tm_s1 = tx_mod_in;
      nxt_st.tm_s2 = st_ff.tm_s1;
      nxt_st.lm_s1 = load_mod_in;
      nxt_st.lm_s2 = st_ff.lm_s1;
      nxt_st.xc_s1 = ext_clk_present;
      nxt_st.xc_s2 = st_ff.xc_s1;
      nxt_st.osc_ok_d = ctl.osc_ok;
      // answer phase: read data and error flag from flip-flops
      if (acc) begin
         nxt_st.slverr = 1'b0;
         nxt_st.rdata  = 32'h0000_0000;
         if (ram_hit) begin
            if (st_ff.mode != nfcfm_pkg::NFCFM_READY)
               nxt_st.slverr = 1'b1;
            else
               nxt_st.rdata = {24'h00_0000, ram[ram_idx]};
         end else begin
            unique case (paddr)
               nfcfm_pkg::OFF_OP_CTRL:  nxt_st.rdata[7:0]  = st_ff.op;
               nfcfm_pkg::OFF_IO_CFG:   nxt_st.rdata[7:0]  = st_ff.io;
               nfcfm_pkg::OFF_MODE_DEF: nxt_st.rdata[7:0]  = st_ff.mdef;
               nfcfm_pkg::OFF_TX_DRV:   nxt_st.rdata[7:0]  = st_ff.txd;
               nfcfm_pkg::OFF_LM_CFG:   nxt_st.rdata[15:0] = st_ff.lm;
               nfcfm_pkg::OFF_RX_CFG:   nxt_st.rdata[7:0]  = st_ff.rxc;
               nfcfm_pkg::OFF_WAKE_CFG: nxt_st.rdata[15:0] = st_ff.wake;
               nfcfm_pkg::OFF_STATUS:   nxt_st.rdata[4:0]  =
                  {st_ff.mode, ctl.osc_ok, st_ff.wake_flag,
                   st_ff.osc_flag};
               default:                 nxt_st.slverr = 1'b1;
            endcase
         end
      end
      // register writes take effect at the committing edge only
      if (commit && pwrite && !st_ff.slverr && !ram_hit) begin
         unique case (paddr)
            nfcfm_pkg::OFF_OP_CTRL:  nxt_st.op   = pwdata[7:0];
            nfcfm_pkg::OFF_IO_CFG:   nxt_st.io   = pwdata[7:0];
            nfcfm_pkg::OFF_MODE_DEF: nxt_st.mdef = pwdata[7:0];
            nfcfm_pkg::OFF_TX_DRV:   nxt_st.txd  = pwdata[7:0];
            nfcfm_pkg::OFF_LM_CFG:   nxt_st.lm   = pwdata[15:0];
            nfcfm_pkg::OFF_RX_CFG:   nxt_st.rxc  = pwdata[7:0];
            nfcfm_pkg::OFF_WAKE_CFG: nxt_st.wake = pwdata[15:0];
            nfcfm_pkg::OFF_STATUS: begin
               if (pwdata[nfcfm_pkg::B_ST_OSC])  nxt_st.osc_flag  = 1'b0;
               if (pwdata[nfcfm_pkg::B_ST_WAKE]) nxt_st.wake_flag = 1'b0;
            end
            default: ;
         endcase
      end
      // events set after the clear so a coinciding set wins
      if (ctl.osc_ok && !st_ff.osc_ok_d) nxt_st.osc_flag  = 1'b1;
      if (ctl.wake_evt)                  nxt_st.wake_flag = 1'b1;
      // operating mode follows the operation control register
      if (st_ff.op[nfcfm_pkg::B_OSC_EN])
         nxt_st.mode = nfcfm_pkg::NFCFM_READY;
      else if (st_ff.op == (8'h01 << nfcfm_pkg::B_WAKEUP))
         nxt_st.mode = nfcfm_pkg::NFCFM_WAKEUP;
      else
         nxt_st.mode = nfcfm_pkg::NFCFM_PWRDN;
      // target mode: new impedance only while the extracted clock runs
      if (st_ff.xc_s2)
         nxt_st.imp = st_ff.lm_s2 ? st_ff.lm[7:4] : st_ff.lm[3:0];
      // driver outputs
      if (st_ff.mdef[nfcfm_pkg::B_PT_MODE] && st_ff.lm[nfcfm_pkg::B_LM_DRI])
         nxt_st.segs = seg_mask(st_ff.imp);
      else
         nxt_st.segs = seg_mask(st_ff.txd[3:0]);
      nxt_st.drv_a = tx_on & ~(ook & st_ff.tm_s2) &
                     ~(st_ff.io[nfcfm_pkg::B_SINGLE] &
                       st_ff.io[nfcfm_pkg::B_OUT_SEL]);
      nxt_st.drv_b = tx_on & ~(ook & st_ff.tm_s2) &
                     ~(st_ff.io[nfcfm_pkg::B_SINGLE] &
                       ~st_ff.io[nfcfm_pkg::B_OUT_SEL]);
      nxt_st.am_sup = tx_on & ~ook & st_ff.tm_s2;
      // external gate idles low when the external path is off
      nxt_st.ext_gate = st_ff.lm[nfcfm_pkg::B_LM_EXT] &
                        (st_ff.lm_s2 ^ st_ff.lm[nfcfm_pkg::B_LM_INV]);
   end
   ////////////////////////////////////////////////////////////////////////
   // state register; reset clears the operation control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff      <= '0;
         st_ff.mode <= nfcfm_pkg::NFCFM_PWRDN;
      end else begin
         st_ff <= nxt_st;
      end
   end
   // target ram holds data only, no reset needed
   always_ff @(posedge pclk) begin
      if (ram_wr) ram[ram_idx] <= pwdata[7:0];
   end
   ////////////////////////////////////////////////////////////////////////
   // outputs
   assign prdata   = st_ff.rdata;
   assign pready   = st_ff.rdy;
   assign pslverr  = st_ff.rdy & st_ff.slverr;
   assign irq      = st_ff.osc_flag | st_ff.wake_flag;
   assign meas_start       = ctl.meas_start;
   assign regulator_on     = st_ff.op[nfcfm_pkg::B_OSC_EN];
   assign osc_on           = st_ff.op[nfcfm_pkg::B_OSC_EN];
   assign fifo_access_ok   = (st_ff.mode == nfcfm_pkg::NFCFM_READY);
   assign antenna_driver_a = st_ff.drv_a;
   assign antenna_driver_b = st_ff.drv_b;
   assign driver_segments  = st_ff.segs;
   assign am_supply_sel    = st_ff.am_sup;
   assign amplitude_mod_level = st_ff.txd[7:4];
   assign external_gate_out   = st_ff.ext_gate;
   assign slow_ramp        = st_ff.io[nfcfm_pkg::B_SLOW_UP];
   assign rx_power         = st_ff.op[nfcfm_pkg::B_RX_EN];
   assign rx_auto_channel  = ~st_ff.op[nfcfm_pkg::B_RX_SINGLE] &
                             ~st_ff.op[nfcfm_pkg::B_RX_MAN];
   assign rx_channel_q     = ~rx_auto_channel &
                             st_ff.rxc[nfcfm_pkg::B_CH_PICK];
   assign demod_mixer_sel  = st_ff.rxc[nfcfm_pkg::B_DEMOD_MIX];
   ////////////////////////////////////////////////////////////////////////
   // checks

   // power and operating mode; mode lags the control register one edge
   AST_PWRDN_IDLE: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_ff.op == 8'h00 |-> !regulator_on ##1 !fifo_access_ok)
      else $error("not powered down with clear control");
   AST_RAM_REFUSED: assert property (
      @(posedge pclk) disable iff (!presetn)
      acc && ram_hit && st_ff.mode != nfcfm_pkg::NFCFM_READY
      |=> pready && pslverr)
      else $error("target ram reached outside ready mode");
   AST_RAM_GRANT: assert property (
      @(posedge pclk) disable iff (!presetn)
      acc && ram_hit && st_ff.mode == nfcfm_pkg::NFCFM_READY
      |=> pready && !pslverr)
      else $error("target ram refused in ready mode");
   AST_READY_ENTRY: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(st_ff.op[7]) |=> st_ff.mode == nfcfm_pkg::NFCFM_READY)
      else $error("ready mode not entered");

   // interrupt sources; a clear in the same cycle must not hide an event
   AST_OSC_IRQ: assert property (
      @(posedge pclk) disable iff (!presetn)
      $rose(ctl.osc_ok) |=> ##[0:1] irq)
      else $error("no interrupt after oscillator settled");
   AST_OSC_SET_WINS: assert property (
      @(posedge pclk) disable iff (!presetn)
      ctl.osc_ok && !st_ff.osc_ok_d |=> st_ff.osc_flag)
      else $error("oscillator flag lost against a clear");
   AST_WAKE_ONLY: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_ff.mode == nfcfm_pkg::NFCFM_WAKEUP |-> $past(st_ff.op) == 8'h04)
      else $error("wake-up mode with other control bits set");
   AST_WAKE_IRQ: assert property (
      @(posedge pclk) disable iff (!presetn)
      ctl.wake_evt |=> irq)
      else $error("no interrupt after a presence change");

   // transmitter drivers
   AST_TX_OFF: assert property (
      @(posedge pclk) disable iff (!presetn)
      !tx_on |=> !antenna_driver_a && !antenna_driver_b)
      else $error("drivers active with transmitter off");
   AST_SINGLE_DRV: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_ff.io[0] && !st_ff.io[1] && $stable(st_ff.io) |=> !antenna_driver_b)
      else $error("second driver active in single mode");
   AST_OOK_GAP: assert property (
      @(posedge pclk) disable iff (!presetn)
      tx_on && ook && st_ff.tm_s2 |=> !antenna_driver_a && !antenna_driver_b)
      else $error("carrier driven during ook gap");
   AST_AM_SUPPLY: assert property (
      @(posedge pclk) disable iff (!presetn)
      tx_on && !ook && st_ff.tm_s2 |=> am_supply_sel)
      else $error("am supply not used while modulating");
   AST_SEG_MAP: assert property (
      @(posedge pclk) disable iff (!presetn)
      !st_ff.mdef[1] && st_ff.txd[3:0] == 4'h0 && $stable(st_ff.txd)
      |=> driver_segments == 8'hFF)
      else $error("lowest resistance does not enable all segments");

   // load modulation; the gate output is one edge behind its inputs
   AST_EXT_GATE: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_ff.lm[9] && $stable(st_ff.lm) |=>
      external_gate_out == ($past(st_ff.lm_s2) ^ $past(st_ff.lm[10])))
      else $error("external gate level wrong");
   AST_EXT_PLAIN: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_ff.lm[9] && !st_ff.lm[10] |=>
      external_gate_out == $past(st_ff.lm_s2))
      else $error("external gate does not follow load modulation");
   AST_IMP_HOLD: assert property (
      @(posedge pclk) disable iff (!presetn)
      !st_ff.xc_s2 |=> $stable(st_ff.imp))
      else $error("impedance moved without extracted clock");

   // receiver
   AST_RX_ONLY: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_ff.op[6] && !st_ff.op[3] |-> rx_power ##1 !antenna_driver_a)
      else $error("receiver not powered alone");
   AST_AUTO_CH: assert property (
      @(posedge pclk) disable iff (!presetn)
      !st_ff.op[5] && !st_ff.op[4] |-> rx_auto_channel && !rx_channel_q)
      else $error("channel not automatic");
   AST_CH_PICK: assert property (
      @(posedge pclk) disable iff (!presetn)
      st_ff.op[5] || st_ff.op[4] |->
      !rx_auto_channel && rx_channel_q == st_ff.rxc[0])
      else $error("manual channel not taken from the pick bit");

endmodule : nfcfm_top

// ==== verilog/nfcfm_wake_tmr.sv ====
// Purpose: wake-up timer paced by the rc oscillator
// Assumes: rc clock far slower than pclk; it is sampled, not a domain
// Notes:   a period of zero is treated as one tick
`timescale 1ns/1ps
module nfcfm_wake_tmr (
   input wire logic  pclk,
   input wire logic  presetn,
   input wire logic  rc_clk,
   nfcfm_ctl_if.wake ctl
);
   typedef struct packed {
      logic       rc_s1;
      logic       rc_s2;
      logic       rc_d;
      logic [7:0] cnt;
      logic       start;
      logic       evt;
   } nfcfm_wake_t;
   nfcfm_wake_t st_ff, nxt_st;
   logic tick;
   assign tick = st_ff.rc_s2 & ~st_ff.rc_d;
   ////////////////////////////////////////////////////////////////////////
   // schedule a measurement each period, flag a change vs reference
   always_comb begin
      nxt_st       = st_ff;
      nxt_st.rc_s1 = rc_clk;
      nxt_st.rc_s2 = st_ff.rc_s1;
      nxt_st.rc_d  = st_ff.rc_s2;
      nxt_st.start = 1'b0;
      nxt_st.evt   = 1'b0;
      if (!ctl.wake_run) begin
         nxt_st.cnt = 8'h00;
      end else if (tick) begin
         if (st_ff.cnt == 8'h00 || st_ff.cnt == 8'h01) begin
            nxt_st.cnt   = ctl.wake_period;
            nxt_st.start = 1'b1;
         end else begin
            nxt_st.cnt = st_ff.cnt - 8'h01;
         end
      end
      if (ctl.wake_run && ctl.meas_done &&
          ctl.meas_value != ctl.wake_ref) begin
         nxt_st.evt = 1'b1;
      end
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) st_ff <= '0;
      else          st_ff <= nxt_st;
   end
   assign ctl.meas_start = st_ff.start;
   assign ctl.wake_evt   = st_ff.evt;
endmodule : nfcfm_wake_tmr
